// *** hdl/cpm_top.sv ***
// Local design decisions: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_top #(
  parameter int NUM_PERIPH = 32,
  parameter int NUM_GPREG = 5
) (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [11:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // System events
  input wire cpm_pkg::cpm_wake_t WAKE_I,
  input wire logic SLEEP_REQ_I,
  input wire logic EXT_ROUTED_I,
  // Clock steering
  output cpm_pkg::cpm_src_t MAIN_SRC_O,
  output cpm_pkg::cpm_src_t CLOCK_OUT_FUNCTION_SRC_O,
  output cpm_pkg::cpm_fro_t FRO_FREQ_O,
  output logic [7:0] CORE_DIV_O,
  output logic [NUM_PERIPH-1:0] PERIPH_CLK_EN_O,
  // Power state
  output cpm_pkg::cpm_power_t POWER_O,
  output logic CORE_RUN_O,
  output logic FLASH_INIT_O
);
  import cpm_pkg::*;

  initial begin
    if (NUM_PERIPH < 1 || NUM_PERIPH > 32 || NUM_GPREG < 1 || NUM_GPREG > 8) begin
      $error("cpm_top: unsupported parameter values");
    end
  end

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  cpm_src_t main_sel_reg;
  cpm_src_t clock_out_function_sel_reg;
  cpm_fro_t fro_sel_reg;
  logic [31:0] pwrcfg_reg;
  logic [31:0] gate_reg;
  logic [7:0] coreldiv_reg;
  logic [`CPM_WAKE_SRCS-1:0] wake_en_reg;
  logic [2:0] mode_req_reg;
  logic go_reg;
  logic lock_reg;
  logic [7:0] wpin_en_reg;
  logic [31:0] gp_reg [NUM_GPREG];
  cpm_mode_t mode_reg;
  cpm_mode_t mode_next;
  cpm_src_t mux_active;
  logic mux_switching;
  logic refused_reg;
  logic flash_init_reg;
  // Latched address phase
  logic dph_reg;
  logic dph_wr_reg;
  logic [11:0] dph_addr_reg;

  // Reset release through two flip-flops
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // Address falls within gp register bank
  function automatic logic is_gp(input logic [11:0] a);
    return (a >= `CPM_OFF_GPREG0) && (a < `CPM_OFF_GPREG0 + 12'(NUM_GPREG * 4));
  endfunction : is_gp

  // Drop a source that cannot run: unpowered low-power osc or unrouted external input
  function automatic cpm_src_t usable_src(input cpm_src_t s, input logic lp_on, input logic routed);
    cpm_src_t r;
    r = s;
    if (s == CPM_SRC_LPOSC && !lp_on) begin
      r = CPM_SRC_NONE;
    end
    if (s == CPM_SRC_EXT && !routed) begin
      r = CPM_SRC_NONE;
    end
    return r;
  endfunction : usable_src

  // Target mode for a request code; deepest mode only when unlocked
  function automatic cpm_mode_t req_mode(input logic [2:0] code, input logic locked);
    cpm_mode_t m;
    case (code)
      `CPM_REQ_DSLEEP: m = CPM_M_DSLEEP;
      `CPM_REQ_PDOWN: m = CPM_M_PDOWN;
      `CPM_REQ_DPDOWN: m = locked ? CPM_M_RUN : CPM_M_DPDOWN;
      default: m = CPM_M_SLEEP;
    endcase
    return m;
  endfunction : req_mode

  // AHB address phase capture, zero wait state
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      dph_reg <= 1'b0;
      dph_wr_reg <= 1'b0;
      dph_addr_reg <= 12'h000;
    end else if (HREADY_I) begin
      dph_reg <= HSEL_I && HTRANS_I[1];
      dph_wr_reg <= HWRITE_I;
      dph_addr_reg <= {HADDR_I[11:2], 2'b00};
    end
  end

  // Register writes
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      main_sel_reg <= CPM_SRC_FRO;
      fro_sel_reg <= cpm_fro_t'(`CPM_RST_FROSEL);
      clock_out_function_sel_reg <= CPM_SRC_NONE;
      pwrcfg_reg <= `CPM_RST_PWRCFG;
      gate_reg <= `CPM_RST_CLKGATE;
      coreldiv_reg <= `CPM_RST_COREDIV;
      wake_en_reg <= '0;
      mode_req_reg <= 3'h0;
      lock_reg <= 1'b0;
      wpin_en_reg <= 8'h00;
      go_reg <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (dph_reg && dph_wr_reg) begin
        case (dph_addr_reg)
          `CPM_OFF_MAINSEL: main_sel_reg <= cpm_src_t'(HWDATA_I[2:0]);
          `CPM_OFF_FROSEL: begin
            if (HWDATA_I[1:0] <= 2'h2) begin
              fro_sel_reg <= cpm_fro_t'(HWDATA_I[1:0]);
            end
          end
          `CPM_OFF_PWRCFG: pwrcfg_reg <= HWDATA_I;
          `CPM_OFF_CLKGATE: gate_reg <= HWDATA_I;
          `CPM_OFF_COREDIV: coreldiv_reg <= HWDATA_I[7:0];
          `CPM_OFF_CLOCK_OUT_FUNCTION: clock_out_function_sel_reg <= cpm_src_t'(HWDATA_I[2:0]);
          `CPM_OFF_WAKEEN: wake_en_reg <= HWDATA_I[`CPM_WAKE_SRCS-1:0];
          `CPM_OFF_MODE: begin
            mode_req_reg <= HWDATA_I[`CPM_MODE_LSB +: 3];
            go_reg <= HWDATA_I[`CPM_MODE_GO_BIT];
          end
          `CPM_OFF_PMULOCK: lock_reg <= HWDATA_I[0];
          `CPM_OFF_WPINEN: wpin_en_reg <= HWDATA_I[7:0];
          default: ;
        endcase
      end
    end
  end

  // Retained registers, no reset of any kind, kept in deepest mode
  always_ff @(posedge SYS_CLK_I) begin
    for (int i = 0; i < NUM_GPREG; i++) begin
      if (dph_reg && dph_wr_reg && dph_addr_reg == `CPM_OFF_GPREG0 + 12'(i * 4)) begin
        gp_reg[i] <= HWDATA_I;
      end
    end
  end

  // Read data and bus answer
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      HRDATA_O <= 32'h0000_0000;
      if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
        case ({HADDR_I[11:2], 2'b00})
          `CPM_OFF_MAINSEL: HRDATA_O <= {29'h0, main_sel_reg};
          `CPM_OFF_FROSEL: HRDATA_O <= {30'h0, fro_sel_reg};
          `CPM_OFF_PWRCFG: HRDATA_O <= pwrcfg_reg;
          `CPM_OFF_CLKGATE: HRDATA_O <= gate_reg;
          `CPM_OFF_COREDIV: HRDATA_O <= {24'h0, coreldiv_reg};
          `CPM_OFF_CLOCK_OUT_FUNCTION: HRDATA_O <= {29'h0, clock_out_function_sel_reg};
          `CPM_OFF_WAKEEN: HRDATA_O <= {27'h0, wake_en_reg};
          `CPM_OFF_MODE: HRDATA_O <= {29'h0, mode_req_reg};
          `CPM_OFF_PMULOCK: HRDATA_O <= {31'h0, lock_reg};
          `CPM_OFF_WPINEN: HRDATA_O <= {24'h0, wpin_en_reg};
          `CPM_OFF_STATUS: HRDATA_O <= {25'h0, refused_reg, mux_active, mode_reg};
          default: begin
            if (is_gp(HADDR_I)) begin
              HRDATA_O <= gp_reg[3'((HADDR_I - `CPM_OFF_GPREG0) >> 2)];
            end
          end
        endcase
      end
    end
  end

  // Source mux with settle gap
  cpm_clk_mux u_main_mux (
    .clk_i(SYS_CLK_I),
    .rst_n_i(rst_n),
    .sel_i(usable_src(main_sel_reg, pwrcfg_reg[`CPM_PWR_LPOSC_BIT], EXT_ROUTED_I)),
    .ext_routed_i(EXT_ROUTED_I),
    .switching_o(mux_switching),
    .active_o(mux_active)
  );

  // Enabled deep wake: here and at the interrupt controller
  logic deep_wake;
  logic dpd_wake;
  assign deep_wake = WAKE_I.reset_req || (|(WAKE_I.irq_wake & wake_en_reg));
  assign dpd_wake = WAKE_I.reset_req || (|(WAKE_I.wake_pins & wpin_en_reg));

  // Request to leave run mode, from the mode register or the core
  logic enter_req;
  assign enter_req = (mode_reg == CPM_M_RUN) && (go_reg || SLEEP_REQ_I);

  // Power mode sequencer
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      CPM_M_RUN: begin
        if (enter_req) begin
          mode_next = req_mode(mode_req_reg, lock_reg);
        end
      end
      CPM_M_SLEEP: if (WAKE_I.irq_any || WAKE_I.reset_req) mode_next = CPM_M_RUN;
      CPM_M_DSLEEP: if (deep_wake) mode_next = CPM_M_RUN;
      CPM_M_PDOWN: if (deep_wake) mode_next = CPM_M_RUN;
      CPM_M_DPDOWN: if (dpd_wake) mode_next = CPM_M_RUN;
      default: mode_next = CPM_M_RUN;
    endcase
  end

  // Mode state
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= CPM_M_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Refusal flag, a refused entry wins over the clear by a new request
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      refused_reg <= 1'b0;
    end else begin
      if (enter_req && req_mode(mode_req_reg, lock_reg) == CPM_M_RUN) begin
        refused_reg <= 1'b1;
      end else if (go_reg) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // Flash controller init pulse after any reset
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      flash_init_reg <= 1'b1;
    end else begin
      flash_init_reg <= 1'b0;
    end
  end

  // Registered outputs toward clocks and power
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MAIN_SRC_O <= CPM_SRC_FRO;
      CLOCK_OUT_FUNCTION_SRC_O <= CPM_SRC_NONE;
      FRO_FREQ_O <= cpm_fro_t'(`CPM_RST_FROSEL);
      CORE_DIV_O <= `CPM_RST_COREDIV;
      PERIPH_CLK_EN_O <= '0;
      POWER_O <= '0;
      CORE_RUN_O <= 1'b0;
      FLASH_INIT_O <= 1'b0;
    end else begin
      MAIN_SRC_O <= mux_active;
      CLOCK_OUT_FUNCTION_SRC_O <= usable_src(clock_out_function_sel_reg, pwrcfg_reg[`CPM_PWR_LPOSC_BIT], EXT_ROUTED_I);
      FRO_FREQ_O <= fro_sel_reg;
      CORE_DIV_O <= coreldiv_reg;
      FLASH_INIT_O <= flash_init_reg;
      // Core held while no source drives the main clock
      CORE_RUN_O <= (mode_reg == CPM_M_RUN) && !mux_switching && !flash_init_reg &&
                    (mux_active != CPM_SRC_NONE);
      POWER_O.core_clk_en <= (mode_reg == CPM_M_RUN) && !mux_switching;
      POWER_O.main_pwr_on <= (mode_reg != CPM_M_DPDOWN);
      POWER_O.brownout_en <= (mode_reg != CPM_M_DPDOWN) && pwrcfg_reg[`CPM_PWR_BROWNOUT_BIT];
      POWER_O.lposc_en <= (mode_reg != CPM_M_DPDOWN) && pwrcfg_reg[`CPM_PWR_LPOSC_BIT];
      case (mode_reg)
        CPM_M_RUN, CPM_M_SLEEP: begin
          POWER_O.fro_en <= 1'b1;
          POWER_O.fro_out_en <= 1'b1;
          POWER_O.flash_on <= 1'b1;
          POWER_O.flash_standby <= 1'b0;
          POWER_O.analog_on <= 1'b1;
          POWER_O.periph_clk_en <= 1'b1;
          PERIPH_CLK_EN_O <= gate_reg[NUM_PERIPH-1:0];
        end
        CPM_M_DSLEEP: begin
          POWER_O.fro_en <= (main_sel_reg == CPM_SRC_FRO || main_sel_reg == CPM_SRC_FRO_DIV);
          POWER_O.fro_out_en <= 1'b0;
          POWER_O.flash_on <= 1'b1;
          POWER_O.flash_standby <= 1'b1;
          POWER_O.analog_on <= 1'b0;
          POWER_O.periph_clk_en <= 1'b0;
          PERIPH_CLK_EN_O <= '0;
        end
        default: begin
          POWER_O.fro_en <= 1'b0;
          POWER_O.fro_out_en <= 1'b0;
          POWER_O.flash_on <= 1'b0;
          POWER_O.flash_standby <= 1'b0;
          POWER_O.analog_on <= 1'b0;
          POWER_O.periph_clk_en <= 1'b0;
          PERIPH_CLK_EN_O <= '0;
        end
      endcase
    end
  end
endmodule : cpm_top

// *** hdl/cpm_defines.svh ***
`ifndef CPM_DEFINES_SVH
`define CPM_DEFINES_SVH
// Register byte offsets
`define CPM_OFF_MAINSEL 12'h000
`define CPM_OFF_FROSEL 12'h004
`define CPM_OFF_PWRCFG 12'h008
`define CPM_OFF_CLKGATE 12'h00C
`define CPM_OFF_COREDIV 12'h010
`define CPM_OFF_CLOCK_OUT_FUNCTION 12'h014
`define CPM_OFF_WAKEEN 12'h018
`define CPM_OFF_MODE 12'h01C
`define CPM_OFF_PMULOCK 12'h020
`define CPM_OFF_WPINEN 12'h024
`define CPM_OFF_STATUS 12'h028
`define CPM_OFF_GPREG0 12'h040
// Reset values
`define CPM_RST_FROSEL 2'h1
`define CPM_RST_PWRCFG 32'h0000_0000
`define CPM_RST_CLKGATE 32'hFFFF_FFFF
`define CPM_RST_COREDIV 8'h01
// Field positions in the run power configuration register
`define CPM_PWR_LPOSC_BIT 0
`define CPM_PWR_BROWNOUT_BIT 1
`define CPM_PWR_FLASH_BIT 2
// Mode register fields
`define CPM_MODE_LSB 0
`define CPM_MODE_GO_BIT 4
// Requested mode codes in the mode register
`define CPM_REQ_SLEEP 3'h1
`define CPM_REQ_DSLEEP 3'h2
`define CPM_REQ_PDOWN 3'h3
`define CPM_REQ_DPDOWN 3'h4
// Wake sources
`define CPM_WAKE_SRCS 5
// Frequencies in kHz
`define CPM_FRO_KHZ_15 15000
`define CPM_FRO_KHZ_12 12000
`define CPM_FRO_KHZ_9 9000
`define CPM_LPOSC_KHZ 1000
`define CPM_EXT_MAX_KHZ 15000
// Clock switch settle cycles
`define CPM_SWITCH_CYC 4'h4
`endif

// *** hdl/cpm_pkg.sv ***
package cpm_pkg;
  typedef enum logic [2:0] {CPM_SRC_NONE, CPM_SRC_FRO, CPM_SRC_FRO_DIV, CPM_SRC_LPOSC, CPM_SRC_EXT}
    cpm_src_t;
  typedef enum logic [1:0] {CPM_FRO_15, CPM_FRO_12, CPM_FRO_9} cpm_fro_t;
  typedef enum logic [2:0] {CPM_M_RUN, CPM_M_SLEEP, CPM_M_DSLEEP, CPM_M_PDOWN, CPM_M_DPDOWN} cpm_mode_t;
  // Wake request bundle from the system
  typedef struct packed {
    logic [7:0] wake_pins;
    logic [4:0] irq_wake;
    logic irq_any;
    logic reset_req;
  } cpm_wake_t;
  // Power and clock enables toward the chip
  typedef struct packed {
    logic core_clk_en;
    logic fro_en;
    logic fro_out_en;
    logic lposc_en;
    logic brownout_en;
    logic flash_on;
    logic flash_standby;
    logic analog_on;
    logic periph_clk_en;
    logic main_pwr_on;
  } cpm_power_t;
endpackage : cpm_pkg

// *** hdl/cpm_clk_mux.sv ***
`timescale 1ns/1ps
`include "cpm_defines.svh"
// Source select with a settle gap so no runt pulse reaches consumers
module cpm_clk_mux (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Selection
  input wire cpm_pkg::cpm_src_t sel_i,
  input wire logic ext_routed_i,
  // Output
  output logic switching_o,
  output cpm_pkg::cpm_src_t active_o
);
  import cpm_pkg::*;
  cpm_src_t want;
  logic [3:0] gap_reg;
  // External clock only counts once routed to a pin
  always_comb begin
    want = sel_i;
    if (sel_i == CPM_SRC_EXT && !ext_routed_i) begin
      want = CPM_SRC_NONE;
    end
  end
  // Park on none for a short gap between sources
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_o <= CPM_SRC_FRO;
      gap_reg <= 4'h0;
    end else if (gap_reg != 4'h0) begin
      gap_reg <= gap_reg - 4'h1;
      if (gap_reg == 4'h1) begin
        active_o <= want;
      end
    end else if (want != active_o) begin
      gap_reg <= `CPM_SWITCH_CYC;
      active_o <= CPM_SRC_NONE;
    end
  end
  assign switching_o = (gap_reg != 4'h0);
endmodule : cpm_clk_mux

// *** sim/cpm_top_chk.sv ***
`timescale 1ns/1ps
module cpm_top_chk (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // Observed ports
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic EXT_ROUTED_I,
  input wire cpm_pkg::cpm_src_t MAIN_SRC_O,
  input wire cpm_pkg::cpm_src_t CLOCK_OUT_FUNCTION_SRC_O,
  input wire cpm_pkg::cpm_fro_t FRO_FREQ_O,
  input wire cpm_pkg::cpm_power_t POWER_O,
  input wire logic CORE_RUN_O,
  input wire logic FLASH_INIT_O
);
  import cpm_pkg::*;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // Main source just dropped to the gap value
  sequence left_src_s;
    MAIN_SRC_O == CPM_SRC_NONE && $past(MAIN_SRC_O) != CPM_SRC_NONE;
  endsequence
  // Gap with the core held
  sequence gap_s;
    (MAIN_SRC_O == CPM_SRC_NONE && !CORE_RUN_O)[*4];
  endsequence
  switch_gap_a: assert property (left_src_s |-> gap_s)
    else $error("clock switch gap too short or core released");
  run_clock_a: assert property (CORE_RUN_O |-> POWER_O.core_clk_en && MAIN_SRC_O != CPM_SRC_NONE)
    else $error("core released without a clock");
  ext_gate_a: assert property ((!EXT_ROUTED_I)[*3] |-> MAIN_SRC_O != CPM_SRC_EXT && CLOCK_OUT_FUNCTION_SRC_O != CPM_SRC_EXT)
    else $error("unrouted external clock in use");
  flash_pulse_a: assert property ($rose(FLASH_INIT_O) |=> !FLASH_INIT_O)
    else $error("flash init pulse longer than one cycle");
  deep_sleep_a: assert property (POWER_O.flash_standby |->
    !POWER_O.fro_out_en && !POWER_O.analog_on && !POWER_O.periph_clk_en)
    else $error("deep-sleep left something powered");
  dpd_off_a: assert property (!POWER_O.main_pwr_on |->
    !POWER_O.lposc_en && !POWER_O.brownout_en && !POWER_O.core_clk_en)
    else $error("deep power-down left a source on");
  bus_okay_a: assert property (HRESP_O == 1'b0 && HREADYOUT_O == 1'b1)
    else $error("bus response not zero-wait okay");
  reset_src_a: assert property (disable iff (1'b0) !RST_N_I |=>
    MAIN_SRC_O == CPM_SRC_FRO && FRO_FREQ_O == CPM_FRO_12 && !CORE_RUN_O)
    else $error("reset clock defaults wrong");
endmodule : cpm_top_chk

bind cpm_top cpm_top_chk u_chk (.SYS_CLK_I, .RST_N_I, .HREADYOUT_O, .HRESP_O, .EXT_ROUTED_I, .MAIN_SRC_O,
  .CLOCK_OUT_FUNCTION_SRC_O, .FRO_FREQ_O, .POWER_O, .CORE_RUN_O, .FLASH_INIT_O);

// *** sim/cpm_core_model.sv ***
`timescale 1ns/1ps
// Core side: one-cycle sleep request and held wake lines
module cpm_core_model (
  // Clock
  input wire logic clk_i,
  // Core status and bench commands
  input wire logic core_run_i,
  input wire logic wfi_cmd_i,
  input wire cpm_pkg::cpm_wake_t wake_cmd_i,
  // Toward the block
  output logic sleep_req_o,
  output cpm_pkg::cpm_wake_t wake_o
);
  import cpm_pkg::*;
  initial begin
    sleep_req_o = 1'b0;
    wake_o = '0;
  end
  // Sleep request only from a running core
  always @(posedge clk_i) begin
    sleep_req_o <= wfi_cmd_i && core_run_i;
    wake_o <= wake_cmd_i;
  end
endmodule : cpm_core_model

// *** sim/cpm_top_bench.sv ***
`timescale 1ns/1ps
`include "cpm_defines.svh"
module cpm_top_bench;
  import cpm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ext_routed = 1'b0;
  logic wfi = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  cpm_wake_t wake_cmd = '0;
  cpm_wake_t wake;
  logic sleep_req, hready, hresp, core_run, flash_init;
  logic [31:0] hrdata, periph_en;
  cpm_src_t main_src, clock_out_function_src;
  cpm_fro_t fro_freq;
  logic [7:0] core_div;
  cpm_power_t pwr;
  int n_mismatch = 0;
  int checks_done = 0;
  initial forever #4 clk = ~clk;
  cpm_top #(.NUM_PERIPH(32), .NUM_GPREG(5)) uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .WAKE_I(wake),
    .SLEEP_REQ_I(sleep_req), .EXT_ROUTED_I(ext_routed), .MAIN_SRC_O(main_src), .CLOCK_OUT_FUNCTION_SRC_O(clock_out_function_src),
    .FRO_FREQ_O(fro_freq), .CORE_DIV_O(core_div), .PERIPH_CLK_EN_O(periph_en), .POWER_O(pwr),
    .CORE_RUN_O(core_run), .FLASH_INIT_O(flash_init));
  cpm_core_model core (.clk_i(clk), .core_run_i(core_run), .wfi_cmd_i(wfi), .wake_cmd_i(wake_cmd),
    .sleep_req_o(sleep_req), .wake_o(wake));
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // One single-word transfer, ready and read data taken at the rising edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task wait_run(input logic e);
    repeat (60) if (core_run !== e) @(negedge clk);
    chk(core_run, e, "core run");
  endtask : wait_run
  task set_wake(input cpm_wake_t v);
    @(posedge clk);
    wake_cmd <= v;
  endtask : set_wake
  task t_reset;
    logic seen;
    seen = 1'b0;
    repeat (4) @(posedge clk);
    chk(main_src, CPM_SRC_FRO, "reset src");
    chk(fro_freq, CPM_FRO_12, "reset fro");
    chk(core_div, 8'h01, "reset div");
    rst_n <= 1'b1;
    repeat (10) begin @(negedge clk); seen |= flash_init; end
    chk(seen, 1'b1, "flash init");
    wait_run(1'b1);
    chk(pwr.fro_en, 1'b1, "fro on");
    chk(periph_en, 32'hFFFF_FFFF, "gates");
  endtask : t_reset
  task t_src;
    for (int i = 0; i < 4; i++) begin
      wr(`CPM_OFF_FROSEL, 32'(i));
      idle(3);
      chk(fro_freq, (i == 3) ? CPM_FRO_9 : i, "fro sel");
    end
    wr(`CPM_OFF_MAINSEL, 32'h2); idle(10); chk(main_src, CPM_SRC_FRO_DIV, "div");
    wr(`CPM_OFF_MAINSEL, 32'h3); idle(10); chk(main_src, CPM_SRC_NONE, "lposc off");
    wr(`CPM_OFF_PWRCFG, 32'h3); idle(10); chk(main_src, CPM_SRC_LPOSC, "lposc");
    wr(`CPM_OFF_MAINSEL, 32'h0); idle(10); chk(main_src, CPM_SRC_NONE, "none");
    chk(core_run, 1'b0, "held");
    wr(`CPM_OFF_MAINSEL, 32'h4); idle(10); chk(main_src, CPM_SRC_NONE, "ext unrouted");
    wr(`CPM_OFF_MAINSEL, 32'h1); wait_run(1'b1);
    wr(`CPM_OFF_CLOCK_OUT_FUNCTION, 32'h4); idle(10); chk(clock_out_function_src, CPM_SRC_NONE, "out unrouted");
    @(posedge clk); ext_routed <= 1'b1;
    wr(`CPM_OFF_MAINSEL, 32'h4); idle(10); chk(main_src, CPM_SRC_EXT, "ext routed");
    wr(`CPM_OFF_MAINSEL, 32'h1); wait_run(1'b1);
    for (int i = 0; i < 5; i++) begin
      wr(`CPM_OFF_CLOCK_OUT_FUNCTION, 32'(i)); idle(10); chk(clock_out_function_src, i, "clock out");
    end
    @(posedge clk); ext_routed <= 1'b0;
    idle(10); chk(clock_out_function_src, CPM_SRC_NONE, "out unrouted");
  endtask : t_src
  task t_gate;
    logic [31:0] r;
    wr(`CPM_OFF_CLKGATE, 32'h0000_00A5); wr(`CPM_OFF_COREDIV, 32'h3); idle(3);
    chk(periph_en, 32'h0000_00A5, "gates");
    chk(core_div, 8'h03, "divider");
    bus(1'b0, 12'h030, 32'h0, r); chk(r, 32'h0, "unmapped");
  endtask : t_gate
  task t_sleep;
    wr(`CPM_OFF_MODE, 32'h1);
    @(posedge clk); wfi <= 1'b1;
    @(posedge clk); wfi <= 1'b0;
    wait_run(1'b0);
    chk(periph_en, 32'h0000_00A5, "periph run");
    set_wake('{wake_pins: 8'hFF, default: '0}); idle(20); chk(core_run, 1'b0, "pins");
    set_wake('{irq_any: 1'b1, default: '0}); wait_run(1'b1);
    set_wake('0);
  endtask : t_sleep
  task t_deep;
    cpm_wake_t w;
    wr(`CPM_OFF_WAKEEN, 32'h1E); wr(`CPM_OFF_MODE, 32'h12); wait_run(1'b0);
    chk(pwr.lposc_en & pwr.brownout_en, 1'b1, "kept on");
    set_wake('{irq_wake: 5'h01, wake_pins: 8'hFF, default: '0}); idle(20);
    chk(core_run, 1'b0, "masked");
    set_wake('{reset_req: 1'b1, default: '0}); wait_run(1'b1);
    set_wake('0); wr(`CPM_OFF_WAKEEN, 32'h1F);
    for (int m = 2; m < 4; m++) begin
      for (int b = 0; b < 6; b++) begin
        wr(`CPM_OFF_MODE, 32'h10 | 32'(m)); wait_run(1'b0);
        chk(pwr.analog_on | pwr.periph_clk_en, 1'b0, "analog");
        chk(m == 2 ? pwr.flash_standby : pwr.flash_on, m == 2, "flash");
        w = '0;
        if (b == 5) w.reset_req = 1'b1;
        else w.irq_wake = 5'(1 << b);
        set_wake(w); wait_run(1'b1);
        set_wake('0);
      end
    end
  endtask : t_deep
  task t_dpd;
    logic [31:0] r;
    wr(`CPM_OFF_PMULOCK, 32'h1); wr(`CPM_OFF_MODE, 32'h14); idle(5);
    chk(core_run, 1'b1, "locked");
    bus(1'b0, `CPM_OFF_STATUS, 32'h0, r); chk(r[6], 1'b1, "refused");
    wr(`CPM_OFF_PMULOCK, 32'h0);
    for (int g = 0; g < 5; g++) wr(`CPM_OFF_GPREG0 + 12'(4 * g), 32'h5A5A_0000 | 32'(g));
    wr(`CPM_OFF_WPINEN, 32'h1); wr(`CPM_OFF_MODE, 32'h14); wait_run(1'b0);
    chk(pwr.main_pwr_on | pwr.lposc_en | pwr.brownout_en, 1'b0, "dpd");
    set_wake('{wake_pins: 8'h02, irq_wake: 5'h1F, irq_any: 1'b1, default: '0}); idle(20);
    chk(core_run, 1'b0, "pin off");
    set_wake('{wake_pins: 8'h01, default: '0}); wait_run(1'b1);
    set_wake('0);
    for (int g = 0; g < 5; g++) begin
      bus(1'b0, `CPM_OFF_GPREG0 + 12'(4 * g), 32'h0, r); chk(r, 32'h5A5A_0000 | 32'(g), "kept");
    end
  endtask : t_dpd
  // Main sequence
  initial begin
    t_reset; t_src; t_gate; t_sleep; t_deep; t_dpd;
    give_verdict;
  end
  // Hang guard
  initial begin
    #(8 * 30000);
    n_mismatch++;
    give_verdict;
  end
endmodule : cpm_top_bench
